// ===== verilog/tcs_top.sv
// Purpose: Timer count source, buffering, input filter and output cutoff
// Assumes: AXI4-Lite slave; all pin inputs are asynchronous to clk
// Notes: Pin outputs are registered; oscillator inputs are edge-sampled
// How it works
// - Channel C route: 000 none, 001-100 pins
// - Channel D route: 000 none, 001-100 pins
// - Route bits 3 and 7 read zero
// - Clock select picks prescaler, pin, oscillators
// - Mode bits make C buffer A, D buffer B
// - Capture pushes old A/B into buffer
// - Compare match reloads A/B from buffer
// - PWM2 reloads B at A match or trigger
// - Buffer C/D still flags compare matches
// - Buffer C/D flags on their pin edges
// - Filter needs three equal samples per level
// - Output drives only while disable bit clear
// - Armed low emergency pin sets all disables
// - Pins release within few clocks of emergency
// - Arm bit is gate register bit seven
`timescale 1ns/1ps
`default_nettype none
module tcs_top (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire tcs_pkg::tcs_pins_in_type pins_in,
	output tcs_pkg::tcs_pins_out_type pins_out
);
	localparam int NPIN = $bits(tcs_pkg::tcs_pins_in_type);

	// One-hot port select; forbidden codes leave the channel unconnected
	function automatic logic [3:0] route_mask(input logic [2:0] sel);
		logic [3:0] m;
		m = 4'h0;
		for (int k = 0; k < 4; k++) begin
			if (sel == 3'(k + 1)) begin
				m[k] = 1'b1;
			end
		end
		return m;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] st);
		return {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
	endfunction

	logic [7:0] chan_cd_pin_route;
	logic [7:0] timer_mode_reg;
	logic [7:0] timer_control_one;
	logic [7:0] io_control;
	logic [7:0] timer_flag_reg;
	logic [7:0] output_gate_reg;
	logic [7:0] filter_control;
	logic [15:0] gen [4];
	logic [15:0] counter_value;

	logic aw_held;
	logic w_held;
	logic [tcs_pkg::IDX_W-1:0] aw_idx;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_en;
	logic [tcs_pkg::IDX_W-1:0] wr_idx;
	logic wr_map;
	logic [31:0] next_rdata;
	logic rd_map;
	logic [tcs_pkg::IDX_W-1:0] rd_idx;

	// Write performs once both halves are held and no response is pending
	assign wr_en = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx = aw_idx;
	assign rd_idx = s_axi_araddr[tcs_pkg::ADDR_W-1:2];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tcs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_idx <= s_axi_awaddr[tcs_pkg::ADDR_W-1:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_en) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? tcs_pkg::RESP_OKAY : tcs_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		wr_map = (wr_idx == tcs_pkg::IDX_PIN_ROUTE) || (wr_idx >= tcs_pkg::IDX_MODE
			&& wr_idx <= tcs_pkg::IDX_COUNT);
	end

	always_comb begin
		next_rdata = 32'h0;
		rd_map = 1'b1;
		unique case (rd_idx)
			tcs_pkg::IDX_PIN_ROUTE: next_rdata[7:0] = chan_cd_pin_route;
			tcs_pkg::IDX_MODE: next_rdata[7:0] = timer_mode_reg;
			tcs_pkg::IDX_CTRL1: next_rdata[7:0] = timer_control_one;
			tcs_pkg::IDX_IOCTL: next_rdata[7:0] = io_control;
			tcs_pkg::IDX_FLAGS: next_rdata[7:0] = timer_flag_reg;
			tcs_pkg::IDX_GATE: next_rdata[7:0] = output_gate_reg;
			tcs_pkg::IDX_FILT: next_rdata[7:0] = filter_control;
			tcs_pkg::IDX_COUNT: next_rdata[15:0] = counter_value;
			default: begin
				if (rd_idx >= tcs_pkg::IDX_GEN_A && rd_idx < tcs_pkg::IDX_COUNT) begin
					next_rdata[15:0] = gen[2'(rd_idx - tcs_pkg::IDX_GEN_A)];
				end else begin
					rd_map = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= tcs_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rd_map ? tcs_pkg::RESP_OKAY : tcs_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Plain control registers; reserved route bits never store
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_cd_pin_route <= tcs_pkg::RST_ROUTE;
			timer_mode_reg <= 8'h00;
			timer_control_one <= 8'h00;
			io_control <= 8'h00;
			filter_control <= 8'h00;
		end else if (wr_en && w_strb[0]) begin
			unique case (wr_idx)
				tcs_pkg::IDX_PIN_ROUTE: chan_cd_pin_route <= w_data[7:0] & tcs_pkg::ROUTE_MASK;
				tcs_pkg::IDX_MODE: timer_mode_reg <= w_data[7:0];
				tcs_pkg::IDX_CTRL1: timer_control_one <= w_data[7:0];
				tcs_pkg::IDX_IOCTL: io_control <= w_data[7:0];
				tcs_pkg::IDX_FILT: filter_control <= w_data[7:0];
				default: ;
			endcase
		end
	end

	// Pin synchronisers; stage one feeds only stage two
	logic [NPIN-1:0] sync1;
	logic [NPIN-1:0] sync2;
	tcs_pkg::tcs_pins_in_type pin_s;
	logic [2:0] src_d;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= '1;
			sync2 <= '1;
		end else begin
			sync1 <= pins_in;
			sync2 <= sync1;
		end
	end
	assign pin_s = sync2;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_d <= 3'h7;
		end else begin
			src_d <= {pin_s.ext_count_clock_pin, pin_s.osc_40mhz_clock, pin_s.fast_osc_clock};
		end
	end

	// Count source select
	logic [4:0] prescale;
	logic tick;
	logic [2:0] cks;
	logic run;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prescale <= 5'h00;
		end else begin
			prescale <= prescale + 5'h01;
		end
	end

	assign cks = timer_control_one[2:0];
	assign run = timer_mode_reg[tcs_pkg::MODE_RUN];

	always_comb begin
		unique case (cks)
			3'h0: tick = 1'b1;
			3'h1: tick = &prescale[0:0];
			3'h2: tick = &prescale[1:0];
			3'h3: tick = &prescale[2:0];
			3'h4: tick = &prescale[4:0];
			tcs_pkg::CKS_EXT: tick = pin_s.ext_count_clock_pin && !src_d[2];
			tcs_pkg::CKS_OSC40: tick = pin_s.osc_40mhz_clock && !src_d[1];
			tcs_pkg::CKS_FAST: tick = pin_s.fast_osc_clock && !src_d[0];
		endcase
	end

	// Channel routing and digital filter
	logic [3:0] mask_c;
	logic [3:0] mask_d;
	logic [4:0] raw_in;
	logic [4:0] filt_en;
	logic [4:0] level;
	logic [4:0] level_d;
	logic samp;

	assign mask_c = route_mask(chan_cd_pin_route[tcs_pkg::ROUTE_C_LSB +: 3]);
	assign mask_d = route_mask(chan_cd_pin_route[tcs_pkg::ROUTE_D_LSB +: 3]);
	assign raw_in = {pin_s.pwm2_trigger_pin, |(pin_s.chan_d_pin & mask_d),
		|(pin_s.chan_c_pin & mask_c), pin_s.chan_b_pin, pin_s.chan_a_pin};
	assign filt_en = {filter_control[tcs_pkg::FILT_TRIG_EN], filter_control[3:0]};

	always_comb begin
		unique case (filter_control[tcs_pkg::FILT_SAMP_LSB +: 2])
			tcs_pkg::FSMP_CLK: samp = 1'b1;
			tcs_pkg::FSMP_DIV8: samp = &prescale[2:0];
			tcs_pkg::FSMP_DIV32: samp = &prescale[4:0];
			default: samp = tick;
		endcase
	end

	for (genvar i = 0; i < 5; i++) begin : g_filt
		logic [tcs_pkg::FILT_SAMPLES-1:0] hist;
		logic held;
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				hist <= '0;
				held <= 1'b0;
			end else if (samp) begin
				hist <= {hist[tcs_pkg::FILT_SAMPLES-2:0], raw_in[i]};
				if (&hist) begin
					held <= 1'b1;
				end else if (~|hist) begin
					held <= 1'b0;
				end
			end
		end
		assign level[i] = filt_en[i] ? held : raw_in[i];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level_d <= 5'h00;
		end else begin
			level_d <= level;
		end
	end

	// Mode decode, match and capture events
	logic buf_c;
	logic buf_d;
	logic pwm;
	logic pwm2;
	logic [3:0] is_cap;
	logic [3:0] is_out;
	logic [3:0] match;
	logic [3:0] cap_edge;
	logic trig_edge;
	logic clr_a;

	assign buf_c = timer_mode_reg[tcs_pkg::MODE_BUF_C];
	assign buf_d = timer_mode_reg[tcs_pkg::MODE_BUF_D];
	assign pwm = timer_mode_reg[tcs_pkg::MODE_PWM];
	assign pwm2 = timer_mode_reg[tcs_pkg::MODE_PWM2];
	assign is_cap = (pwm || pwm2) ? 4'h0 : io_control[3:0];
	assign is_out = pwm2 ? 4'h2 : (pwm ? 4'he : ~io_control[3:0]);
	assign trig_edge = pwm2 && (level[4] && !level_d[4]);
	assign clr_a = timer_control_one[tcs_pkg::CTRL1_CLR_A] || pwm || pwm2;

	for (genvar i = 0; i < 4; i++) begin : g_evt
		logic fall;
		assign fall = io_control[tcs_pkg::IOCTL_FALL_LSB + i];
		assign match[i] = run && tick && !is_cap[i] && (counter_value == gen[i]);
		assign cap_edge[i] = run && is_cap[i] && (fall ? (!level[i] && level_d[i])
			: (level[i] && !level_d[i]));
	end

	// Counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			counter_value <= 16'h0000;
		end else if (run && tick) begin
			counter_value <= (clr_a && match[0]) ? 16'h0000 : counter_value + 16'h0001;
		end else if (wr_en && wr_idx == tcs_pkg::IDX_COUNT) begin
			counter_value <= merge16(counter_value, w_data, w_strb);
		end
	end

	// General registers and buffer transfers
	for (genvar i = 0; i < 4; i++) begin : g_gen
		logic buf_mine;
		logic [15:0] pair;
		assign buf_mine = (i == 0) ? buf_c : ((i == 1) ? buf_d : 1'b0);
		assign pair = gen[(i + 2) % 4];
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				gen[i] <= tcs_pkg::RST_GEN;
			end else if (i == 1 && pwm2 && buf_d && (match[0] || trig_edge)) begin
				gen[i] <= pair;
			end else if (i < 2 && cap_edge[i]) begin
				gen[i] <= counter_value;
			end else if (i < 2 && buf_mine && match[i] && !pwm2) begin
				gen[i] <= pair;
			end else if (i == 2 && buf_c && cap_edge[0]) begin
				gen[i] <= pair;
			end else if (i == 3 && buf_d && cap_edge[1]) begin
				gen[i] <= pair;
			end else if (i >= 2 && cap_edge[i] && !(i == 2 ? buf_c : buf_d)) begin
				gen[i] <= counter_value;
			end else if (wr_en && wr_idx == tcs_pkg::IDX_GEN_A + 10'(i)) begin
				gen[i] <= merge16(gen[i], w_data, w_strb);
			end
		end
	end

	// Flags: write zero clears, a same-cycle event wins
	logic [7:0] flag_set;
	logic [7:0] flag_keep;
	assign flag_set = {run && tick && (&counter_value), 3'h0, match | cap_edge};
	assign flag_keep = (wr_en && w_strb[0] && wr_idx == tcs_pkg::IDX_FLAGS) ? w_data[7:0] : 8'hff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_flag_reg <= 8'h00;
		end else begin
			timer_flag_reg <= (timer_flag_reg & flag_keep) | flag_set;
		end
	end

	// Output gate with emergency cutoff
	logic cut;
	logic [7:0] next_gate;
	assign cut = output_gate_reg[tcs_pkg::GATE_ARM] && !pin_s.emergency_stop_pin;

	always_comb begin
		next_gate = output_gate_reg;
		if (wr_en && w_strb[0] && wr_idx == tcs_pkg::IDX_GATE) begin
			next_gate = w_data[7:0] & 8'h8f;
		end
		if (cut) begin
			next_gate[3:0] = 4'hf;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			output_gate_reg <= tcs_pkg::RST_GATE;
		end else begin
			output_gate_reg <= next_gate;
		end
	end

	// Waveforms; compare toggles, PWM sets at A match and clears at own match
	logic [3:0] wave;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wave <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (pwm2) begin
					if (i == 1 && match[0]) begin
						wave[i] <= 1'b0;
					end else if (i == 1 && match[1]) begin
						wave[i] <= 1'b1;
					end
				end else if (pwm) begin
					if (i > 0 && match[i]) begin
						wave[i] <= 1'b0;
					end else if (i > 0 && match[0]) begin
						wave[i] <= 1'b1;
					end
				end else if (match[i]) begin
					wave[i] <= !wave[i];
				end
			end
		end
	end

	// Enables take the next gate so a cutoff acts on the same edge
	logic [3:0] drive;
	assign drive = is_out & ~next_gate[3:0];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pins_out <= '0;
		end else begin
			pins_out.chan_a_out <= wave[0];
			pins_out.chan_a_oe <= drive[0];
			pins_out.chan_b_out <= wave[1];
			pins_out.chan_b_oe <= drive[1];
			pins_out.chan_c_out <= {4{wave[2]}} & mask_c;
			pins_out.chan_c_oe <= {4{drive[2]}} & mask_c;
			pins_out.chan_d_out <= {4{wave[3]}} & mask_d;
			pins_out.chan_d_oe <= {4{drive[3]}} & mask_d;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/tcs_pkg.sv
// Purpose: Shared constants and carriers of the timer common block
// Assumes: Register index times four gives the AXI byte address
// Notes: Eight-bit registers sit in the low byte of their word
package tcs_pkg;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	// Register word indices
	localparam logic [IDX_W-1:0] IDX_MODE = 10'h170;
	localparam logic [IDX_W-1:0] IDX_CTRL1 = 10'h171;
	localparam logic [IDX_W-1:0] IDX_IOCTL = 10'h172;
	localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h173;
	localparam logic [IDX_W-1:0] IDX_GATE = 10'h174;
	localparam logic [IDX_W-1:0] IDX_FILT = 10'h175;
	localparam logic [IDX_W-1:0] IDX_GEN_A = 10'h176;
	localparam logic [IDX_W-1:0] IDX_COUNT = 10'h17a;
	localparam logic [IDX_W-1:0] IDX_PIN_ROUTE = 10'h183;
	// Reset values
	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic [7:0] RST_GATE = 8'h0f;
	localparam logic [15:0] RST_GEN = 16'hffff;
	// Field positions
	localparam int ROUTE_C_LSB = 0;
	localparam int ROUTE_D_LSB = 4;
	localparam logic [7:0] ROUTE_MASK = 8'h77;
	localparam int MODE_RUN = 0;
	localparam int MODE_BUF_C = 1;
	localparam int MODE_BUF_D = 2;
	localparam int MODE_PWM = 3;
	localparam int MODE_PWM2 = 4;
	localparam int CTRL1_CLR_A = 3;
	localparam int IOCTL_FALL_LSB = 4;
	localparam int FLAG_OVF = 7;
	localparam int GATE_ARM = 7;
	localparam int FILT_TRIG_EN = 4;
	localparam int FILT_SAMP_LSB = 5;
	localparam int FILT_SAMPLES = 3;
	// Count source codes
	localparam logic [2:0] CKS_EXT = 3'h5;
	localparam logic [2:0] CKS_OSC40 = 3'h6;
	localparam logic [2:0] CKS_FAST = 3'h7;
	// Filter sampling clock codes and AXI response codes
	localparam logic [1:0] FSMP_CLK = 2'h0;
	localparam logic [1:0] FSMP_DIV8 = 2'h1;
	localparam logic [1:0] FSMP_DIV32 = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic chan_a_pin;
		logic chan_b_pin;
		logic [3:0] chan_c_pin;
		logic [3:0] chan_d_pin;
		logic pwm2_trigger_pin;
		logic ext_count_clock_pin;
		logic emergency_stop_pin;
		logic osc_40mhz_clock;
		logic fast_osc_clock;
	} tcs_pins_in_type;

	typedef struct packed {
		logic chan_a_out;
		logic chan_a_oe;
		logic chan_b_out;
		logic chan_b_oe;
		logic [3:0] chan_c_out;
		logic [3:0] chan_c_oe;
		logic [3:0] chan_d_out;
		logic [3:0] chan_d_oe;
	} tcs_pins_out_type;
endpackage

// ===== verification/tcs_top_checker.sv
// Purpose: Port-level checks of the timer common block
// Assumes: Bench offers write address and data in the same cycle
// Notes: Arm shadow follows gate writes with lane 0 strobed
`timescale 1ns/1ps
`default_nettype none
module tcs_top_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire tcs_pkg::tcs_pins_in_type pins_in,
	input wire tcs_pkg::tcs_pins_out_type pins_out
);
	logic arm_q;
	logic cut_q;
	logic [9:0] ar_idx;
	logic [11:0] oe_all;
	logic gate_wr;
	assign oe_all = {pins_out.chan_a_oe, pins_out.chan_b_oe, pins_out.chan_c_oe, pins_out.chan_d_oe};
	assign gate_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr[11:2] == tcs_pkg::IDX_GATE && s_axi_wstrb[0];
	// A gate write with lane 0 strobed clears the cutoff shadow, since software may rearm
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arm_q <= 1'b0;
			cut_q <= 1'b0;
		end else if (gate_wr) begin
			arm_q <= s_axi_wdata[tcs_pkg::GATE_ARM];
			cut_q <= 1'b0;
		end else if (arm_q && !pins_in.emergency_stop_pin) begin
			cut_q <= 1'b1;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ar_idx <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ar_idx <= s_axi_araddr[11:2];
		end
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_cut_fast;
		arm_q && !pins_in.emergency_stop_pin |-> ##[1:3] oe_all == 12'h000;
	endproperty
	a_cut_fast: assert property (p_cut_fast) else $error("outputs driven after stop");
	property p_cut_hold;
		cut_q && $past(cut_q, 3) |-> oe_all == 12'h000;
	endproperty
	a_cut_hold: assert property (p_cut_hold) else $error("outputs back before clear");
	property p_route_zero;
		s_axi_rvalid && ar_idx == tcs_pkg::IDX_PIN_ROUTE |-> s_axi_rdata[31:7] == 25'h0
			&& !s_axi_rdata[3];
	endproperty
	a_route_zero: assert property (p_route_zero) else $error("route spare bits set");
	property p_c_onehot;
		$onehot0(pins_out.chan_c_oe);
	endproperty
	a_c_onehot: assert property (p_c_onehot) else $error("channel c on two pins");
	property p_d_onehot;
		$onehot0(pins_out.chan_d_oe);
	endproperty
	a_d_onehot: assert property (p_d_onehot) else $error("channel d on two pins");
	property p_b_after;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write response late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_ready_low;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("second write accepted");
	property p_r_after;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_after: assert property (p_r_after) else $error("read data late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	c_cut: cover property (arm_q && !pins_in.emergency_stop_pin);
	c_route_rd: cover property (s_axi_rvalid && ar_idx == tcs_pkg::IDX_PIN_ROUTE);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == tcs_pkg::RESP_SLVERR);
endmodule
bind tcs_top tcs_top_checker u_chk (.clk(clk), .arst_n(arst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pins_in(pins_in),
	.pins_out(pins_out));
`default_nettype wire

// ===== verification/tcs_pin_model.sv
// Purpose: Pin-side partner driving timer inputs and oscillators
// Assumes: Called from the bench process, one request at a time
// Notes: Oscillators run free at periods of 8 and 16 clocks
`timescale 1ns/1ps
`default_nettype none
module tcs_pin_model (
	input wire logic clk,
	output tcs_pkg::tcs_pins_in_type pins
);
	logic a = 1'b0;
	logic ext = 1'b0;
	logic stop_n = 1'b1;
	logic [3:0] c = 4'h0;
	logic [3:0] div = 4'h0;
	assign pins = {a, a, c, c, a, ext, stop_n, div[2], div[3]};
	always @(posedge clk) begin
		div <= div + 4'h1;
	end
	task automatic pulse_a(input int w);
		@(posedge clk);
		a <= 1'b1;
		repeat (w) @(posedge clk);
		a <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic pulse_c(input int i);
		@(posedge clk);
		c[i] <= 1'b1;
		repeat (6) @(posedge clk);
		c[i] <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	// Three high and four low clocks, the shortest pulse allowed
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			ext <= 1'b1;
			repeat (3) @(posedge clk);
			ext <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	// Pin idles high as if pulled up
	task automatic set_stop(input logic v);
		@(posedge clk);
		stop_n <= v;
	endtask
endmodule
`default_nettype wire

// ===== verification/timer_common_source_buffer_cutoff_tb.sv
// Purpose: Register-level tests of count source, buffers, filter and cutoff
// Assumes: Route code n selects bit n-1 of the channel pin vectors
// Notes: Count-source checks allow a few ticks of bus slack
`timescale 1ns/1ps
`default_nettype none
module timer_common_source_buffer_cutoff_tb;
	logic clk = 1'b0;
	logic arst_n;
	logic [tcs_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	wire tcs_pkg::tcs_pins_in_type pins_in;
	tcs_pkg::tcs_pins_out_type pins_out;
	int fail_count = 0;
	int compares = 0;
	int per [8] = '{1, 2, 4, 8, 32, 0, 8, 16};
	logic [31:0] v;
	logic [1:0] r;
	always #2 clk = ~clk;
	tcs_top uut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .pins_in(pins_in), .pins_out(pins_out));
	tcs_pin_model pin (.clk(clk), .pins(pins_in));
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang;
		chk(32'h0, 32'h1);
		close_out();
	endtask
	// Ready is raised only after the answer shows, so a stalled response is exercised
	task automatic xw(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		if (n == 100) hang();
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic xr(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		if (n == 100) hang();
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		logic [1:0] rs;
		xw(idx, d, rs);
		chk({30'h0, rs}, {30'h0, tcs_pkg::RESP_OKAY});
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] rs;
		xr(idx, d, rs);
		chk(d & mask, exp);
	endtask
	initial begin
		arst_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rdc(tcs_pkg::IDX_PIN_ROUTE, 32'hffffffff, 32'h0);
		rdc(tcs_pkg::IDX_GATE, 32'hffffffff, 32'h0f);
		rdc(tcs_pkg::IDX_GEN_A, 32'hffffffff, 32'hffff);
		xr(10'h3ff, v, r);
		chk({30'h0, r}, {30'h0, tcs_pkg::RESP_SLVERR});
		xw(10'h3ff, 32'h1, r);
		chk({30'h0, r}, {30'h0, tcs_pkg::RESP_SLVERR});
		wr(tcs_pkg::IDX_PIN_ROUTE, 32'hff);
		rdc(tcs_pkg::IDX_PIN_ROUTE, 32'hffffffff, 32'h77);
		wr(tcs_pkg::IDX_PIN_ROUTE, 32'h44);
		rdc(tcs_pkg::IDX_PIN_ROUTE, 32'hffffffff, 32'h44);
		$display("test reset and routing done");
		for (int k = 0; k < 8; k++) begin
			if (k == 5) continue;
			wr(tcs_pkg::IDX_CTRL1, k);
			wr(tcs_pkg::IDX_COUNT, 32'h0);
			wr(tcs_pkg::IDX_MODE, 32'h1);
			repeat (64 * per[k] - 5) @(posedge clk);
			wr(tcs_pkg::IDX_MODE, 32'h0);
			xr(tcs_pkg::IDX_COUNT, v, r);
			compares++;
			if (((v & 32'hffff) >= 60 && (v & 32'hffff) <= 68) !== 1'b1) begin
				fail_count++;
				$display("unexpected at %0t: got %h expected %h", $time, v, 32'h40);
			end
		end
		wr(tcs_pkg::IDX_CTRL1, 32'h5);
		wr(tcs_pkg::IDX_COUNT, 32'h0);
		wr(tcs_pkg::IDX_MODE, 32'h1);
		pin.ext_pulses(5);
		wr(tcs_pkg::IDX_MODE, 32'h0);
		rdc(tcs_pkg::IDX_COUNT, 32'hffff, 32'h5);
		$display("test count sources done");
		wr(tcs_pkg::IDX_CTRL1, 32'h0);
		wr(tcs_pkg::IDX_COUNT, 32'h0);
		wr(tcs_pkg::IDX_GEN_A, 32'h10);
		wr(tcs_pkg::IDX_GEN_A + 10'h2, 32'h20);
		wr(tcs_pkg::IDX_IOCTL, 32'h0);
		wr(tcs_pkg::IDX_FLAGS, 32'h0);
		wr(tcs_pkg::IDX_MODE, 32'h3);
		repeat (100) @(posedge clk);
		wr(tcs_pkg::IDX_MODE, 32'h0);
		rdc(tcs_pkg::IDX_GEN_A, 32'hffff, 32'h20);
		rdc(tcs_pkg::IDX_FLAGS, 32'h5, 32'h5);
		wr(tcs_pkg::IDX_GEN_A + 10'h2, 32'h55);
		wr(tcs_pkg::IDX_PIN_ROUTE, 32'h03);
		wr(tcs_pkg::IDX_IOCTL, 32'h05);
		wr(tcs_pkg::IDX_FLAGS, 32'h0);
		wr(tcs_pkg::IDX_MODE, 32'h3);
		pin.pulse_a(6);
		rdc(tcs_pkg::IDX_GEN_A + 10'h2, 32'hffff, 32'h20);
		rdc(tcs_pkg::IDX_FLAGS, 32'h5, 32'h1);
		pin.pulse_c(0);
		rdc(tcs_pkg::IDX_FLAGS, 32'h4, 32'h0);
		pin.pulse_c(2);
		rdc(tcs_pkg::IDX_FLAGS, 32'h4, 32'h4);
		wr(tcs_pkg::IDX_MODE, 32'h0);
		$display("test buffers done");
		wr(tcs_pkg::IDX_FLAGS, 32'h0);
		wr(tcs_pkg::IDX_FILT, 32'h01);
		wr(tcs_pkg::IDX_IOCTL, 32'h01);
		wr(tcs_pkg::IDX_MODE, 32'h1);
		pin.pulse_a(2);
		rdc(tcs_pkg::IDX_FLAGS, 32'h1, 32'h0);
		pin.pulse_a(5);
		rdc(tcs_pkg::IDX_FLAGS, 32'h1, 32'h1);
		wr(tcs_pkg::IDX_MODE, 32'h0);
		wr(tcs_pkg::IDX_FILT, 32'h0);
		wr(tcs_pkg::IDX_GEN_A, 32'hffff);
		wr(tcs_pkg::IDX_GEN_A + 10'h3, 32'h33);
		wr(tcs_pkg::IDX_MODE, 32'h15);
		pin.pulse_a(6);
		rdc(tcs_pkg::IDX_GEN_A + 10'h1, 32'hffff, 32'h33);
		$display("test filter done");
		wr(tcs_pkg::IDX_IOCTL, 32'h0);
		wr(tcs_pkg::IDX_MODE, 32'h1);
		wr(tcs_pkg::IDX_GATE, 32'h80);
		repeat (3) @(posedge clk);
		chk({31'h0, pins_out.chan_a_oe}, 32'h1);
		pin.set_stop(1'b0);
		repeat (4) @(posedge clk);
		chk({31'h0, pins_out.chan_a_oe}, 32'h0);
		rdc(tcs_pkg::IDX_GATE, 32'hff, 32'h8f);
		pin.set_stop(1'b1);
		repeat (10) @(posedge clk);
		rdc(tcs_pkg::IDX_GATE, 32'hff, 32'h8f);
		wr(tcs_pkg::IDX_GATE, 32'h80);
		repeat (3) @(posedge clk);
		chk({31'h0, pins_out.chan_a_oe}, 32'h1);
		wr(tcs_pkg::IDX_GATE, 32'h0);
		pin.set_stop(1'b0);
		repeat (6) @(posedge clk);
		pin.set_stop(1'b1);
		rdc(tcs_pkg::IDX_GATE, 32'hff, 32'h0);
		wr(tcs_pkg::IDX_MODE, 32'h0);
		$display("test cutoff done");
		close_out();
	end
endmodule
`default_nettype wire
